/* spc_pkg.sv */
// package for the stop mode power control block
package spc_pkg;
	// register byte offsets on the avalon slave
	localparam logic [3:0] SPC_CTRL_OFS = 4'h0;
	localparam logic [3:0] SPC_STAT_OFS = 4'h4;
	localparam logic [3:0] SPC_PARAM_OFS = 4'h8;
	// ctrl field positions
	localparam int CTRL_HALT_EN_BIT = 0;
	localparam int CTRL_DEEP_REQ_BIT = 1;
	localparam int CTRL_VDET_EN_BIT = 2;
	localparam int CTRL_FRC_EN_BIT = 3;
	localparam int CTRL_FRC_HALT_BIT = 4;
	localparam int CTRL_LFR_EN_BIT = 5;
	localparam int CTRL_TEMP_ON_BIT = 6;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int PARAM_BYTES = 64;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// debug status/control bit position, serial access only
	localparam int DBG_EN_BIT = 7;
	localparam logic [7:0] DBG_STATUS_HALTED = 8'h40;
	// debug serial command codes
	localparam logic [1:0] DCMD_READ_STATUS = 2'h0;
	localparam logic [1:0] DCMD_WRITE_CONTROL = 2'h1;
	localparam logic [1:0] DCMD_MEM_STATUS = 2'h2;
	localparam logic [1:0] DCMD_BACKGROUND = 2'h3;

	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_DEEP = 4'h2,
		ST_RETAIN = 4'h4,
		ST_DEBUG = 4'h8
	} spc_state_t;

	typedef struct packed {
		logic periph_clk_en;
		logic dbg_clk_en;
		logic reg_full;
		logic hfo_en;
		logic mfo_en;
		logic rf_chain_en;
		logic io_hiz;
		logic lfr_det_en;
		logic sensor_pwr;
		logic temp_pwr;
		logic timer_clk_en;
		logic conv_run_ok;
	} spc_power_t;
endpackage : spc_pkg

/* spc_power_ctrl.sv */
// stop mode power control: halt selection, wake-up, clock and power gating
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - debug enable gates entry into debug state
// - debug register reached only by serial commands
// - debug clocks kept running in halt when debug enabled
// - regulator full when debug enabled at halt
// - deepest halt with debug becomes retained halt
// - memory status commands return halt error while halted
// - background command wakes retained halt into debug state
// - peripheral clocks off in halt except wakeup
// - deepest halt forces pins high impedance
// - deepest wake resets modules, ram lost
// - 64-byte parameter store never reset
// - low-freq osc and wakeup unit always on
// - free counter runs when enabled and halt bit clear, also in halt
// - medium osc in halt only for measure or rf
// - high-freq osc off in every halt
// - converter runs in retained halt, reset after deep
// - receiver detectors follow sampling select in halt
// - timer clock stops in halt, reset after deep
// - regulator standby in halt except voltage/debug retained halt
// - rf chain on while sending or direct send
// - rf chain on with send bit set outside halt, in halt only with direct send
// - sensor cells only during scheduled measurement
// - halt with halt enable clear forces reset
// - deep halt with voltage detect becomes retained
// - wake from deep restarts from reset vector
// - deep halt refused while interrupts pending
`timescale 1ns/1ps
`default_nettype none
module spc_power_ctrl
	import spc_pkg::*;
#(
	parameter int FRC_WIDTH = 16
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	// avalon-mm slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// core side
	input wire logic i_halt_instr,
	input wire logic i_wake_irq,
	input wire logic i_irq_pending,
	input wire logic i_lf_clk_tick,
	// debug serial command decoder side
	input wire logic i_dcmd_valid,
	input wire logic [1:0] i_dcmd_code,
	input wire logic [7:0] i_dcmd_data,
	input wire logic i_dbg_go,
	output logic o_dcmd_done,
	output logic [7:0] o_dcmd_status,
	// activity from analog and rf blocks
	input wire logic i_measure_busy,
	input wire logic i_rf_busy,
	input wire logic i_rf_send,
	input wire logic i_rf_direct,
	input wire logic i_lfr_sample_sel,
	// outputs
	output spc_power_t o_power,
	output logic [1:0] o_state_code,
	output logic o_illegal_reset,
	output logic o_deep_wake_reset,
	output logic o_fetch_reset_vector,
	output logic o_lfo_en,
	output logic o_pwu_en,
	output logic [FRC_WIDTH-1:0] o_frc_count
);
	// status word carries the low counter byte, so fewer than 8 bits cannot serve
	if (FRC_WIDTH < 8 || FRC_WIDTH > 32) begin : g_chk
		$error("FRC_WIDTH must be 8..32");
	end

	//////////////////////////////////////////////////////////////////////////////
	spc_state_t state_reg;
	logic [31:0] ctrl_reg;
	logic [7:0] dbg_ctrl_reg;
	logic [7:0] param_mem [PARAM_BYTES];
	logic [31:0] rdata_reg;
	logic ack_reg;
	logic [FRC_WIDTH-1:0] frc_reg;
	logic illegal_reg;
	logic deep_wake_reg;
	logic dcmd_done_reg;
	logic [7:0] dcmd_status_reg;
	logic periph_clk_reg;
	logic dbg_clk_reg;
	logic reg_full_reg;
	logic hfo_reg;
	logic mfo_reg;
	logic rf_chain_reg;
	logic io_hiz_reg;
	logic lfr_det_reg;
	logic sensor_pwr_reg;
	logic temp_pwr_reg;
	logic timer_clk_reg;
	logic conv_ok_reg;
	logic vdet_retain_reg;
	logic dbg_en;
	logic halted;
	logic bus_req;

	assign dbg_en = dbg_ctrl_reg[DBG_EN_BIT];
	assign halted = (state_reg == ST_DEEP) || (state_reg == ST_RETAIN);
	assign bus_req = i_avs_read | i_avs_write;

	function automatic logic [1:0] state_code(input spc_state_t s);
		case (s)
			ST_RUN: state_code = 2'h0;
			ST_DEEP: state_code = 2'h1;
			ST_RETAIN: state_code = 2'h2;
			ST_DEBUG: state_code = 2'h3;
			default: state_code = 2'h0;
		endcase
	endfunction : state_code

	function automatic logic bg_cmd(input logic v, input logic [1:0] c, input logic en);
		bg_cmd = v && (c == DCMD_BACKGROUND) && en;
	endfunction : bg_cmd

	//////////////////////////////////////////////////////////////////////////////
	// halt state machine
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state_reg <= ST_RUN;
			vdet_retain_reg <= 1'b0;
			illegal_reg <= 1'b0;
			deep_wake_reg <= 1'b0;
		end else begin
			illegal_reg <= 1'b0;
			deep_wake_reg <= 1'b0;
			case (state_reg)
				ST_RUN: begin
					if (bg_cmd(i_dcmd_valid, i_dcmd_code, dbg_en)) begin
						state_reg <= ST_DEBUG;
					end else if (i_halt_instr) begin
						if (!ctrl_reg[CTRL_HALT_EN_BIT]) begin
							illegal_reg <= 1'b1;
						end else if (ctrl_reg[CTRL_DEEP_REQ_BIT] && !dbg_en
								&& !ctrl_reg[CTRL_VDET_EN_BIT]) begin
							// pending interrupts keep the core running
							if (!i_irq_pending) begin
								state_reg <= ST_DEEP;
							end
						end else begin
							state_reg <= ST_RETAIN;
							vdet_retain_reg <= ctrl_reg[CTRL_VDET_EN_BIT] | dbg_en;
						end
					end
				end
				ST_DEEP: begin
					if (i_wake_irq) begin
						state_reg <= ST_RUN;
						deep_wake_reg <= 1'b1;
					end
				end
				ST_RETAIN: begin
					if (bg_cmd(i_dcmd_valid, i_dcmd_code, dbg_en)) begin
						state_reg <= ST_DEBUG;
					end else if (i_wake_irq) begin
						state_reg <= ST_RUN;
					end
				end
				ST_DEBUG: begin
					if (i_dbg_go) begin
						state_reg <= ST_RUN;
					end
				end
				default: state_reg <= ST_RUN;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// debug serial commands; debug register has no bus address
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			dbg_ctrl_reg <= 8'h00;
			dcmd_done_reg <= 1'b0;
			dcmd_status_reg <= 8'h00;
		end else begin
			dcmd_done_reg <= i_dcmd_valid;
			if (i_dcmd_valid) begin
				case (i_dcmd_code)
					DCMD_READ_STATUS: dcmd_status_reg <= dbg_ctrl_reg;
					DCMD_WRITE_CONTROL: begin
						dbg_ctrl_reg <= i_dcmd_data;
						dcmd_status_reg <= 8'h00;
					end
					DCMD_MEM_STATUS: begin
						// no memory access while halted
						dcmd_status_reg <= halted ? DBG_STATUS_HALTED : 8'h00;
					end
					default: dcmd_status_reg <= 8'h00;
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, answer on second cycle
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
			if (i_avs_read && !ack_reg) begin
				case (i_avs_address)
					SPC_CTRL_OFS: rdata_reg <= ctrl_reg;
					SPC_STAT_OFS: rdata_reg <= {22'h0, frc_reg[7:0], state_code(state_reg)};
					SPC_PARAM_OFS: rdata_reg <= {24'h0, param_mem[ctrl_reg[13:8]]};
					default: rdata_reg <= UNMAPPED_DATA;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst || deep_wake_reg) begin
			ctrl_reg <= CTRL_RESET;
		end else if (i_avs_write && ack_reg && i_avs_address == SPC_CTRL_OFS) begin
			ctrl_reg <= i_avs_writedata;
		end
	end

	// parameter store has no reset term at all
	always_ff @(posedge i_clk) begin
		// write lands on the edge where waitrequest is low
		if (i_avs_write && ack_reg && i_avs_address == SPC_PARAM_OFS) begin
			param_mem[ctrl_reg[13:8]] <= i_avs_writedata[7:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// free-running counter on low-freq ticks, gated by enable and halt bits, ignores halt state
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			frc_reg <= '0;
		end else if (ctrl_reg[CTRL_FRC_EN_BIT] && !ctrl_reg[CTRL_FRC_HALT_BIT] && i_lf_clk_tick) begin
			frc_reg <= frc_reg + 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// power and clock controls, registered
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			periph_clk_reg <= 1'b0;
		end else begin
			periph_clk_reg <= !halted;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			timer_clk_reg <= 1'b0;
		end else begin
			timer_clk_reg <= !halted;
		end
	end

	// debug logic keeps its clock when debug enabled, peripherals still gated
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			dbg_clk_reg <= 1'b0;
		end else begin
			dbg_clk_reg <= !halted || dbg_en;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			reg_full_reg <= 1'b0;
		end else begin
			reg_full_reg <= !halted || (state_reg == ST_RETAIN && vdet_retain_reg);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			hfo_reg <= 1'b0;
		end else begin
			hfo_reg <= !halted;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			mfo_reg <= 1'b0;
		end else begin
			mfo_reg <= !halted || i_measure_busy || i_rf_busy;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			rf_chain_reg <= 1'b0;
		end else begin
			rf_chain_reg <= i_rf_busy || (i_rf_send && (i_rf_direct || !halted));
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			io_hiz_reg <= 1'b0;
		end else begin
			io_hiz_reg <= (state_reg == ST_DEEP);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			lfr_det_reg <= 1'b0;
		end else begin
			lfr_det_reg <= ctrl_reg[CTRL_LFR_EN_BIT] && (!halted || i_lfr_sample_sel);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			sensor_pwr_reg <= 1'b0;
		end else begin
			sensor_pwr_reg <= i_measure_busy && state_reg != ST_DEEP;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			temp_pwr_reg <= 1'b0;
		end else begin
			temp_pwr_reg <= ctrl_reg[CTRL_TEMP_ON_BIT] && state_reg != ST_DEEP;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			conv_ok_reg <= 1'b0;
		end else begin
			conv_ok_reg <= state_reg != ST_DEEP;
		end
	end

	assign o_power = '{
		periph_clk_en: periph_clk_reg,
		dbg_clk_en: dbg_clk_reg,
		reg_full: reg_full_reg,
		hfo_en: hfo_reg,
		mfo_en: mfo_reg,
		rf_chain_en: rf_chain_reg,
		io_hiz: io_hiz_reg,
		lfr_det_en: lfr_det_reg,
		sensor_pwr: sensor_pwr_reg,
		temp_pwr: temp_pwr_reg,
		timer_clk_en: timer_clk_reg,
		conv_run_ok: conv_ok_reg
	};
	assign o_state_code = state_code(state_reg);
	assign o_illegal_reset = illegal_reg;
	assign o_deep_wake_reset = deep_wake_reg;
	assign o_fetch_reset_vector = deep_wake_reg;
	assign o_lfo_en = 1'b1;
	assign o_pwu_en = 1'b1;
	assign o_frc_count = frc_reg;
	assign o_avs_readdata = rdata_reg;
	assign o_avs_waitrequest = bus_req & ~ack_reg;
	assign o_dcmd_done = dcmd_done_reg;
	assign o_dcmd_status = dcmd_status_reg;
endmodule : spc_power_ctrl
`default_nettype wire

/* spc_power_monitor.sv */
// concurrent checks on the stop mode power control ports
`timescale 1ns/1ps
`default_nettype none
module spc_power_monitor
	import spc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_halt_instr,
	input wire logic i_irq_pending,
	input wire logic i_dcmd_valid,
	input wire logic [1:0] i_dcmd_code,
	input wire logic i_measure_busy,
	input wire logic i_rf_busy,
	input wire logic [7:0] o_dcmd_status,
	input wire logic o_dcmd_done,
	input wire spc_power_t o_power,
	input wire logic [1:0] o_state_code,
	input wire logic o_illegal_reset,
	input wire logic o_deep_wake_reset,
	input wire logic o_fetch_reset_vector,
	input wire logic o_lfo_en,
	input wire logic o_pwu_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	a_lfo_always_on: assert property (o_lfo_en && o_pwu_en)
		else $error("lfo or wakeup unit disabled");
	a_halt_clk_gate: assert property ($past(o_state_code) inside {2'h1, 2'h2}
		|-> !o_power.hfo_en && !o_power.periph_clk_en && !o_power.timer_clk_en)
		else $error("clock left running in halt");
	a_deep_pins_hiz: assert property ($past(o_state_code) == 2'h1
		|-> o_power.io_hiz && !o_power.reg_full)
		else $error("deep halt pins or regulator wrong");
	a_mfo_idle_off: assert property (($past(o_state_code) inside {2'h1, 2'h2})
		&& !$past(i_measure_busy) && !$past(i_rf_busy) |-> !o_power.mfo_en)
		else $error("medium osc on while idle in halt");
	a_illegal_cause: assert property (o_illegal_reset
		|-> $past(i_halt_instr) && o_state_code == 2'h0)
		else $error("illegal reset without halt");
	a_deep_irq_refuse: assert property (i_halt_instr && i_irq_pending && o_state_code == 2'h0
		|=> o_state_code != 2'h1)
		else $error("deep halt entered with irq pending");
	a_wake_vector: assert property (o_fetch_reset_vector
		|-> $past(o_state_code) == 2'h1 && o_deep_wake_reset)
		else $error("reset vector fetch without deep wake");
	a_mem_halt_err: assert property (i_dcmd_valid && i_dcmd_code == DCMD_MEM_STATUS
		&& o_state_code inside {2'h1, 2'h2} |=> o_dcmd_status == DBG_STATUS_HALTED)
		else $error("memory command in halt without error");
	a_dcmd_answer: assert property (i_dcmd_valid |=> o_dcmd_done)
		else $error("debug command not answered");
endmodule : spc_power_monitor
//////////////////////////////////////////////////////////////////////////////
bind spc_power_ctrl spc_power_monitor u_mon (.*);
`default_nettype wire

/* spc_core_model.sv */
// core and debug host model driving halt, wake, go and serial commands
`timescale 1ns/1ps
`default_nettype none
module spc_core_model (
	input wire logic i_clk,
	output logic o_halt,
	output logic o_wake,
	output logic o_go,
	output logic o_dvalid,
	output logic [1:0] o_dcode,
	output logic [7:0] o_ddata
);
	logic [2:0] p = 3'h0;
	assign o_halt = p[0];
	assign o_wake = p[1];
	assign o_go = p[2];
	initial begin
		o_dvalid = 1'b0;
		o_dcode = 2'h0;
		o_ddata = 8'h00;
	end
	task pulse(input int k);
		@(posedge i_clk);
		p[k] <= 1'b1;
		@(posedge i_clk);
		p <= 3'h0;
	endtask : pulse
	// debug register only through serial commands; released lines show inverse
	task cmd(input logic [1:0] c, input logic [7:0] d);
		@(posedge i_clk);
		o_dvalid <= 1'b1;
		o_dcode <= c;
		o_ddata <= d;
		@(posedge i_clk);
		o_dvalid <= 1'b0;
		o_dcode <= ~c;
		o_ddata <= ~d;
	endtask : cmd
endmodule : spc_core_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the stop mode power control block
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("CHECK FAILED %0t mismatch", $time); end end
module tb_top;
	import spc_pkg::*;
	logic i_clk = 1'b0, i_nrst = 1'b0, rd, wr, tick, irqp;
	logic meas, rfb, snd, dir, wreq, done, ill, dwr, frv, low_freq_osc, periodic_wakeup_unit;
	logic halt, wake, go, dv;
	logic [1:0] dc, sc;
	logic [3:0] addr = 4'h0;
	logic [7:0] dd, st, s;
	logic [15:0] free_running_counter, c;
	logic [31:0] wd = 32'h0, rdata, q;
	spc_power_t pw;
	int error_cnt = 0, checks = 0;
	always #25 i_clk = ~i_clk;
	spc_core_model u_core (.i_clk(i_clk), .o_halt(halt), .o_wake(wake), .o_go(go),
		.o_dvalid(dv), .o_dcode(dc), .o_ddata(dd));
	spc_power_ctrl #(.FRC_WIDTH(16)) DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_halt_instr(halt), .i_wake_irq(wake), .i_irq_pending(irqp),
		.i_lf_clk_tick(tick), .i_dcmd_valid(dv), .i_dcmd_code(dc), .i_dcmd_data(dd),
		.i_dbg_go(go), .o_dcmd_done(done), .o_dcmd_status(st), .i_measure_busy(meas),
		.i_rf_busy(rfb), .i_rf_send(snd), .i_rf_direct(dir), .i_lfr_sample_sel(s[4]),
		.o_power(pw), .o_state_code(sc), .o_illegal_reset(ill), .o_deep_wake_reset(dwr),
		.o_fetch_reset_vector(frv), .o_lfo_en(low_freq_osc), .o_pwu_en(periodic_wakeup_unit), .o_frc_count(free_running_counter));
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nx
	task summarize();
		if (error_cnt == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// hold request until waitrequest seen low, take data at that edge
	task av(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		@(posedge i_clk);
		while (wreq !== 1'b0 && n < 20) begin
			n++;
			@(posedge i_clk);
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20) error_cnt++;
	endtask : av
	initial begin
		repeat (20000) @(posedge i_clk);
		error_cnt++;
		summarize();
	end
	//////////////////////////////////////////////////////////////////////////
	initial begin
		s = 8'h46;
		{rd, wr, tick, irqp, meas, rfb, snd, dir} <= 8'h00;
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		u_core.cmd(DCMD_BACKGROUND, 8'h00);
		#1 `CK(sc, 2'h0)
		av(1'b1, SPC_CTRL_OFS, 32'h0);
		u_core.pulse(0);
		#1 `CK(ill, 1'b1)
		s = nx(s);
		av(1'b1, SPC_CTRL_OFS, 32'h3F00);
		av(1'b1, SPC_PARAM_OFS, {24'h0, s});
		@(posedge i_clk) i_nrst <= 1'b0;
		@(posedge i_clk) i_nrst <= 1'b1;
		av(1'b1, SPC_CTRL_OFS, 32'h3F00);
		av(1'b0, SPC_PARAM_OFS, 32'h0);
		`CK(q[7:0], s)
		av(1'b1, SPC_CTRL_OFS, 32'h3);
		@(posedge i_clk) irqp <= 1'b1;
		u_core.pulse(0);
		#1 `CK(sc, 2'h0)
		@(posedge i_clk) irqp <= 1'b0;
		u_core.pulse(0);
		#1 `CK(sc, 2'h1)
		@(posedge i_clk) #1 `CK(pw.io_hiz, 1'b1)
		`CK(pw.reg_full, 1'b0)
		u_core.pulse(1);
		#1 `CK(frv, 1'b1)
		`CK({low_freq_osc, periodic_wakeup_unit}, 2'h3)
		av(1'b0, SPC_CTRL_OFS, 32'h0);
		`CK(q, CTRL_RESET)
		av(1'b1, SPC_CTRL_OFS, 32'h7);
		u_core.pulse(0);
		#1 `CK(sc, 2'h2)
		u_core.cmd(DCMD_MEM_STATUS, 8'h00);
		#1 `CK(st, DBG_STATUS_HALTED)
		repeat (6) begin
			@(posedge i_clk);
			s = nx(s);
			{meas, rfb, snd, dir} <= s[3:0];
			repeat (2) @(posedge i_clk);
			#1 `CK(pw.mfo_en, s[3] | s[2])
			`CK(pw.sensor_pwr, s[3])
			`CK(pw.conv_run_ok, 1'b1)
			if (s[1] & s[0]) `CK(pw.rf_chain_en, 1'b1)
		end
		@(posedge i_clk) {meas, rfb, snd, dir} <= 4'h0;
		u_core.pulse(1);
		u_core.cmd(DCMD_WRITE_CONTROL, 8'h80);
		av(1'b1, SPC_CTRL_OFS, 32'h3);
		u_core.pulse(0);
		#1 `CK(sc, 2'h2)
		@(posedge i_clk) #1 `CK(pw.dbg_clk_en, 1'b1)
		`CK(pw.reg_full, 1'b1)
		`CK(pw.periph_clk_en, 1'b0)
		u_core.cmd(DCMD_BACKGROUND, 8'h00);
		#1 `CK(sc, 2'h3)
		u_core.cmd(DCMD_MEM_STATUS, 8'h00);
		#1 `CK(st == DBG_STATUS_HALTED, 1'b0)
		u_core.pulse(2);
		av(1'b1, SPC_CTRL_OFS, 32'h8);
		@(posedge i_clk) #1 c = free_running_counter;
		repeat (3) begin
			@(posedge i_clk) tick <= 1'b1;
			@(posedge i_clk) tick <= 1'b0;
		end
		@(posedge i_clk) #1 `CK(free_running_counter, c + 16'h3)
		summarize();
	end
endmodule : tb_top
`default_nettype wire
